// ===== hdl/spg_consts.svh
`ifndef SPG_CONSTS_SVH
`define SPG_CONSTS_SVH

// register bus
`define SPG_ADDR_W        8
`define SPG_DATA_W        32

// register byte offsets
`define SPG_OFS_LINE_SEL  8'h00
`define SPG_OFS_LINE_CFG  8'h04
`define SPG_OFS_DELAY     8'h08
`define SPG_OFS_WIDTH     8'h0c
`define SPG_OFS_STATUS    8'h10

// line configuration field positions
`define SPG_CFG_DIR_BIT     0
`define SPG_CFG_OUT_INV_BIT 1
`define SPG_CFG_SRC_SEL_BIT 2
`define SPG_CFG_SRC_INV_BIT 3

// status field positions
`define SPG_STS_ACT_LSB   0
`define SPG_STS_PIN_LSB   2

// field encodings
`define SPG_DIR_OUTPUT    1'b1
`define SPG_SRC_INTEG     1'b0
`define SPG_SRC_TRIG      1'b1
`define SPG_LINE_A        1'b0

// timing
`define SPG_CLK_PERIOD_NS 10
`define SPG_US_IN_NS      1000
`define SPG_CYC_PER_US    (`SPG_US_IN_NS / `SPG_CLK_PERIOD_NS)
`define SPG_PRE_W         7
`define SPG_US_W          16

// reset values
`define SPG_RST_SEL       1'b0
`define SPG_RST_DELAY     16'h0000
`define SPG_RST_WIDTH     16'h0000
`define SPG_RST_SRC_INV   1'b0
`define SPG_RST_OUT_INV_A 1'b0
`define SPG_RST_OUT_INV_B 1'b1

`endif

// ===== hdl/spg_pkg.sv
`include "spg_consts.svh"

package spg_pkg;

   typedef struct packed {
      logic src_inv;
      logic src_sel;
      logic out_inv;
   } spg_line_cfg_t;

   typedef struct packed {
      spg_line_cfg_t             cfg;
      logic [`SPG_US_W-1:0]      delay;
      logic [`SPG_US_W-1:0]      width;
   } spg_line_t;

   typedef enum logic [1:0] {
      SPG_IDLE   = 2'b00,
      SPG_WAIT   = 2'b01,
      SPG_ACTIVE = 2'b10
   } spg_state_t;

endpackage

// ===== hdl/spg_sync3.sv
`timescale 1ns/1ps
`include "spg_consts.svh"

module spg_sync3 (
   // clock and reset
   input  wire logic i_clk_sys,
   input  wire logic i_rst_n,
   // asynchronous level in, filtered level out
   input  wire logic i_async,
   output logic      o_level
);

   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic level_reg;
   logic level_next;

   // a change is taken only once the last two stages agree
   assign level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;
   assign o_level    = level_reg;

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s1_reg    <= 1'b0;
         s2_reg    <= 1'b0;
         s3_reg    <= 1'b0;
         level_reg <= 1'b0;
      end else begin
         s1_reg    <= i_async;
         s2_reg    <= s1_reg;
         s3_reg    <= s2_reg;
         level_reg <= level_next;
      end
   end

endmodule

// ===== hdl/spg_top.sv
// Behaviour
// R1: a line selector register picks which of the two lines later config accesses reach.
// R2: each line reports a direction setting, and output is the only direction it takes.
// R3: a per-line output invert bit makes the driven line active low.
// R4: a per-line source invert bit is applied to the source before the timing logic.
// R5: a per-line source select picks integration-active or the hardware trigger input.
// R6: each line waits a programmable whole number of microseconds before asserting.
// R7: the delay starts at the source's active (rising) edge and ends at assertion.
// R8: the two lines are timed fully independently, each with its own settings.
// R9: after reset line a pulses high during integration and line b is its inverse.
// R10: once asserted a line stays active a programmable number of microseconds.
`timescale 1ns/1ps
`include "spg_consts.svh"

module spg_top
   import spg_pkg::*;
(
   // clock and reset
   input  wire logic                   i_clk_sys,
   input  wire logic                   i_rst_n,
   // pulse sources
   input  wire logic                   i_integ_active,
   input  wire logic                   i_trig_in,
   // register port
   input  wire logic [`SPG_ADDR_W-1:0] i_addr,
   input  wire logic [`SPG_DATA_W-1:0] i_wr_data,
   input  wire logic                   i_wr_en,
   input  wire logic                   i_rd_en,
   output logic      [`SPG_DATA_W-1:0] o_rd_data,
   // pulse lines
   output logic                        o_pulse_line_a,
   output logic                        o_pulse_line_b
);

   localparam int NUM_LINES = 2;
   localparam logic [`SPG_PRE_W-1:0] PRE_LAST = `SPG_PRE_W'(`SPG_CYC_PER_US - 1);
   localparam logic [`SPG_PRE_W-1:0] PRE_ZERO = `SPG_PRE_W'(0);
   localparam logic [`SPG_US_W-1:0]  US_ZERO  = `SPG_US_W'(0);
   localparam logic [`SPG_US_W-1:0]  US_ONE   = `SPG_US_W'(1);

   // true when one more elapsed microsecond reaches the programmed limit
   function automatic logic us_hit(input logic [`SPG_US_W-1:0] cnt,
                                   input logic [`SPG_US_W-1:0] limit);
      us_hit = ((cnt + US_ONE) == limit);
   endfunction

   // ---------------------------------------------------------------
   // source synchronisers
   // ---------------------------------------------------------------
   logic integ_lvl;
   logic trig_lvl;

   spg_sync3 u_sync_integ (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_async   (i_integ_active),
      .o_level   (integ_lvl)
   );

   spg_sync3 u_sync_trig (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_async   (i_trig_in),
      .o_level   (trig_lvl)
   );

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   logic                   sel_reg;
   logic                   sel_next;
   spg_line_t              line_reg  [NUM_LINES];
   spg_line_t              line_next [NUM_LINES];
   logic [`SPG_DATA_W-1:0] rd_data_reg;
   logic [`SPG_DATA_W-1:0] rd_data_next;
   logic [`SPG_DATA_W-1:0] rd_mux;

   wire hit_sel    = (i_addr == `SPG_OFS_LINE_SEL);
   wire hit_cfg    = (i_addr == `SPG_OFS_LINE_CFG);
   wire hit_delay  = (i_addr == `SPG_OFS_DELAY);
   wire hit_width  = (i_addr == `SPG_OFS_WIDTH);
   wire hit_status = (i_addr == `SPG_OFS_STATUS);

   wire             wr_sel   = i_wr_en & hit_sel;
   wire             wr_cfg   = i_wr_en & hit_cfg;
   wire             wr_delay = i_wr_en & hit_delay;
   wire             wr_width = i_wr_en & hit_width;
   wire spg_line_t  cur_line = line_reg[sel_reg]; // R1

   // direction bit is not stored: writes to it are dropped
   wire spg_line_cfg_t wr_cfg_val = '{
      src_inv: i_wr_data[`SPG_CFG_SRC_INV_BIT],
      src_sel: i_wr_data[`SPG_CFG_SRC_SEL_BIT],
      out_inv: i_wr_data[`SPG_CFG_OUT_INV_BIT]
   };

   logic [`SPG_DATA_W-1:0] cfg_rd;
   logic [`SPG_DATA_W-1:0] status_rd;
   logic [NUM_LINES-1:0]   line_active;
   logic [NUM_LINES-1:0]   pin_reg;
   logic [NUM_LINES-1:0]   pin_next;

   always_comb begin
      cfg_rd                       = '0;
      cfg_rd[`SPG_CFG_DIR_BIT]     = `SPG_DIR_OUTPUT; // R2
      cfg_rd[`SPG_CFG_OUT_INV_BIT] = cur_line.cfg.out_inv;
      cfg_rd[`SPG_CFG_SRC_SEL_BIT] = cur_line.cfg.src_sel;
      cfg_rd[`SPG_CFG_SRC_INV_BIT] = cur_line.cfg.src_inv;
   end

   always_comb begin
      status_rd = '0;
      status_rd[`SPG_STS_ACT_LSB +: NUM_LINES] = line_active;
      status_rd[`SPG_STS_PIN_LSB +: NUM_LINES] = pin_reg;
   end

   // unmapped addresses read as zero
   assign rd_mux = hit_sel    ? {{(`SPG_DATA_W-1){1'b0}}, sel_reg} :
                   hit_cfg    ? cfg_rd :
                   hit_delay  ? {{(`SPG_DATA_W-`SPG_US_W){1'b0}}, cur_line.delay} :
                   hit_width  ? {{(`SPG_DATA_W-`SPG_US_W){1'b0}}, cur_line.width} :
                   hit_status ? status_rd : '0;

   // read data stand only in the cycle after the strobe
   assign rd_data_next = i_rd_en ? rd_mux : '0;
   assign sel_next     = wr_sel ? i_wr_data[0] : sel_reg; // R1

   always_comb begin
      for (int i = 0; i < NUM_LINES; i++) begin
         line_next[i] = line_reg[i];
         if (sel_reg == 1'(i)) begin
            if (wr_cfg) begin
               line_next[i].cfg = wr_cfg_val; // R3 R4 R5
            end
            if (wr_delay) begin
               line_next[i].delay = i_wr_data[`SPG_US_W-1:0]; // R6
            end
            if (wr_width) begin
               line_next[i].width = i_wr_data[`SPG_US_W-1:0]; // R10
            end
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sel_reg     <= `SPG_RST_SEL;
         rd_data_reg <= '0;
      end else begin
         sel_reg     <= sel_next;
         rd_data_reg <= rd_data_next;
      end
   end

   // both lines reset to integration source, no delay, follow mode;
   // only the output polarity differs
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < NUM_LINES; i++) begin
            line_reg[i].cfg.src_inv <= `SPG_RST_SRC_INV; // R9
            line_reg[i].cfg.src_sel <= `SPG_SRC_INTEG; // R9
            line_reg[i].delay       <= `SPG_RST_DELAY; // R9
            line_reg[i].width       <= `SPG_RST_WIDTH; // R9
         end
         line_reg[0].cfg.out_inv <= `SPG_RST_OUT_INV_A; // R9
         line_reg[1].cfg.out_inv <= `SPG_RST_OUT_INV_B; // R9
      end else begin
         for (int i = 0; i < NUM_LINES; i++) begin
            line_reg[i] <= line_next[i];
         end
      end
   end

   // ---------------------------------------------------------------
   // per-line timing engines
   // ---------------------------------------------------------------
   for (genvar g = 0; g < NUM_LINES; g++) begin : g_line // R8
      spg_state_t              state_reg;
      spg_state_t              state_next;
      logic [`SPG_PRE_W-1:0]   pre_reg;
      logic [`SPG_PRE_W-1:0]   pre_next;
      logic [`SPG_US_W-1:0]    cnt_reg;
      logic [`SPG_US_W-1:0]    cnt_next;
      logic                    src_prev_reg;

      wire src_raw  = (line_reg[g].cfg.src_sel == `SPG_SRC_TRIG) ? trig_lvl
                                                                 : integ_lvl; // R5
      wire src_act  = src_raw ^ line_reg[g].cfg.src_inv; // R4
      wire src_rise = src_act & ~src_prev_reg; // R7
      wire us_done  = (pre_reg == PRE_LAST);
      wire follow   = (line_reg[g].width == US_ZERO);

      // prescaler restarts at the edge, so each delay is whole microseconds
      always_comb begin
         state_next = state_reg;
         pre_next   = (pre_reg == PRE_LAST) ? PRE_ZERO : pre_reg + `SPG_PRE_W'(1);
         cnt_next   = us_done ? cnt_reg + US_ONE : cnt_reg;
         unique case (state_reg)
            SPG_IDLE: begin
               pre_next = PRE_ZERO;
               cnt_next = US_ZERO;
               if (src_rise) begin
                  state_next = (line_reg[g].delay == US_ZERO) ? SPG_ACTIVE
                                                              : SPG_WAIT; // R7
               end
            end
            SPG_WAIT: begin
               if (us_done && us_hit(cnt_reg, line_reg[g].delay)) begin
                  state_next = SPG_ACTIVE; // R6
                  pre_next   = PRE_ZERO;
                  cnt_next   = US_ZERO;
               end
            end
            SPG_ACTIVE: begin
               if (follow) begin
                  if (!src_act) begin
                     state_next = SPG_IDLE;
                  end
               end else if (us_done && us_hit(cnt_reg, line_reg[g].width)) begin
                  state_next = SPG_IDLE; // R10
               end
            end
            default: begin
               state_next = SPG_IDLE;
            end
         endcase
      end

      assign line_active[g] = (state_reg == SPG_ACTIVE);
      assign pin_next[g]    = (state_next == SPG_ACTIVE) ^ line_reg[g].cfg.out_inv; // R3

      always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
         if (!i_rst_n) begin
            state_reg    <= SPG_IDLE;
            pre_reg      <= PRE_ZERO;
            cnt_reg      <= US_ZERO;
            src_prev_reg <= 1'b0;
         end else begin
            state_reg    <= state_next;
            pre_reg      <= pre_next;
            cnt_reg      <= cnt_next;
            src_prev_reg <= src_act;
         end
      end
   end

   // line b idles high after reset, the inverse of line a
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_reg <= {`SPG_RST_OUT_INV_B, `SPG_RST_OUT_INV_A}; // R9
      end else begin
         pin_reg <= pin_next;
      end
   end

   assign o_rd_data      = rd_data_reg;
   assign o_pulse_line_a = pin_reg[0];
   assign o_pulse_line_b = pin_reg[1];

endmodule

// ===== tb/spg_lamp_model.sv
`timescale 1ns/1ps

module spg_lamp_model (
   // sampled strobe line
   input  wire logic        i_clk_sys,
   input  wire logic        i_line,
   // length of the last high period in cycles
   output logic [15:0]      o_last_len
);
   logic [15:0] run_q;
   logic        prev_q;

   initial begin
      run_q = 16'h0;
      prev_q = 1'b0;
      o_last_len = 16'h0;
   end

   always @(posedge i_clk_sys) begin
      prev_q <= i_line;
      run_q <= i_line ? run_q + 16'h1 : 16'h0;
      if (!i_line && prev_q) o_last_len <= run_q;
   end
endmodule

// ===== tb/spg_top_monitor.sv
`timescale 1ns/1ps
`include "spg_consts.svh"

module spg_top_monitor
   import spg_pkg::*;
(
   // watched ports
   input wire logic        i_clk_sys,
   input wire logic        i_rst_n,
   input wire logic        i_integ_active,
   input wire logic        i_trig_in,
   input wire logic [7:0]  i_addr,
   input wire logic [31:0] i_wr_data,
   input wire logic        i_wr_en,
   input wire logic        i_rd_en,
   input wire logic [31:0] o_rd_data,
   input wire logic        o_pulse_line_a,
   input wire logic        o_pulse_line_b
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   // register shadow; cfg is {src_inv, src_sel, out_inv}
   logic        sel_q;
   logic        rd_q;
   logic [7:0]  ra_q;
   logic [2:0]  cfg_q [2];
   logic [15:0] dly_q [2];
   logic [15:0] wid_q [2];
   logic [23:0] since_q;
   logic [23:0] run_q;
   wire  logic        src_a = (cfg_q[0][1] ? i_trig_in : i_integ_active) ^ cfg_q[0][2];
   wire  logic        act_a = o_pulse_line_a ^ cfg_q[0][0];
   wire  logic [23:0] lat_a = dly_q[0] * 24'h64;
   wire  logic [23:0] len_a = wid_q[0] * 24'h64;

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sel_q <= `SPG_RST_SEL;
         cfg_q[0] <= {`SPG_RST_SRC_INV, `SPG_SRC_INTEG, `SPG_RST_OUT_INV_A};
         cfg_q[1] <= {`SPG_RST_SRC_INV, `SPG_SRC_INTEG, `SPG_RST_OUT_INV_B};
         dly_q <= '{`SPG_RST_DELAY, `SPG_RST_DELAY};
         wid_q <= '{`SPG_RST_WIDTH, `SPG_RST_WIDTH};
      end else if (i_wr_en) begin
         case (i_addr)
            `SPG_OFS_LINE_SEL: sel_q <= i_wr_data[0];
            `SPG_OFS_LINE_CFG: cfg_q[sel_q] <= i_wr_data[3:1];
            `SPG_OFS_DELAY:    dly_q[sel_q] <= i_wr_data[15:0];
            `SPG_OFS_WIDTH:    wid_q[sel_q] <= i_wr_data[15:0];
            default: ;
         endcase
      end
   end

   // since_q saturates so a long quiet spell cannot wrap into a false match
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rd_q <= 1'b0;
         ra_q <= 8'h0;
         since_q <= 24'h0;
         run_q <= 24'h0;
      end else begin
         rd_q <= i_rd_en;
         ra_q <= i_addr;
         since_q <= $rose(src_a) ? 24'h1 : since_q + {23'h0, ~&since_q};
         run_q <= act_a ? run_q + 24'h1 : 24'h0;
      end
   end

   a_rd_idle_zero: assert property (!rd_q |-> o_rd_data == 32'h0)
      else $error("read data not zero outside read slot");
   a_rd_unmapped: assert property (rd_q && (ra_q > 8'h10 || ra_q[1:0] != 2'h0) |-> o_rd_data == 32'h0)
      else $error("unmapped read not zero");
   a_sel_readback: assert property (rd_q && ra_q == `SPG_OFS_LINE_SEL |-> o_rd_data == {31'h0, sel_q})
      else $error("selector readback wrong");
   a_cfg_readback: assert property (rd_q && ra_q == `SPG_OFS_LINE_CFG |-> o_rd_data == {28'h0, cfg_q[sel_q], 1'b1})
      else $error("line config readback wrong");
   a_delay_readback: assert property (rd_q && ra_q == `SPG_OFS_DELAY |-> o_rd_data == {16'h0, dly_q[sel_q]})
      else $error("delay readback wrong");
   a_width_readback: assert property (rd_q && ra_q == `SPG_OFS_WIDTH |-> o_rd_data == {16'h0, wid_q[sel_q]})
      else $error("width readback wrong");
   a_follow_assert: assert property ($rose(src_a) && dly_q[0] == 16'h0 && wid_q[0] == 16'h0 |-> ##[3:7] act_a)
      else $error("line a did not follow source rise");
   a_follow_release: assert property ($fell(src_a) && wid_q[0] == 16'h0 |-> ##[3:7] !act_a)
      else $error("line a did not follow source fall");
   a_delay_latency: assert property ($rose(act_a) && cfg_q[0] == $past(cfg_q[0], 4) |-> since_q >= lat_a + 24'h3 && since_q <= lat_a + 24'h7)
      else $error("line a delay off");
   a_width_exact: assert property ($fell(act_a) && wid_q[0] != 16'h0 |-> run_q == len_a)
      else $error("line a width off");
   a_b_inverse: assert property ($rose(i_integ_active) && cfg_q[1] == 3'h1 && dly_q[1] == 16'h0 && wid_q[1] == 16'h0 |-> ##[3:7] !o_pulse_line_b)
      else $error("line b not inverse of integration");

   c_delayed_pulse: cover property ($rose(act_a) && dly_q[0] != 16'h0);
   c_timed_width: cover property ($fell(act_a) && wid_q[0] != 16'h0);
   c_cfg_read: cover property (rd_q && ra_q == `SPG_OFS_LINE_CFG);
endmodule

bind spg_top spg_top_monitor i_mon (
   .i_clk_sys, .i_rst_n, .i_integ_active, .i_trig_in, .i_addr, .i_wr_data,
   .i_wr_en, .i_rd_en, .o_rd_data, .o_pulse_line_a, .o_pulse_line_b
);

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`include "spg_consts.svh"

module tb_top;
   import spg_pkg::*;
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdat;
      logic [31:0] rexp;
   } spg_row_t;
   // rows work on line b, then restore it and select line a again
   localparam spg_row_t ROWS [9] = '{
      '{8'h00, 32'h1, 32'h1}, '{8'h04, 32'he, 32'hf}, '{8'h04, 32'h2, 32'h3},
      '{8'h08, 32'h1234_0007, 32'h7}, '{8'h0c, 32'hffff_0003, 32'h3},
      '{8'h14, 32'h5a5a_5a5a, 32'h0}, '{8'h08, 32'h0, 32'h0},
      '{8'h0c, 32'h0, 32'h0}, '{8'h00, 32'h0, 32'h0}};
   logic        i_clk_sys;
   logic        i_rst_n;
   logic        i_integ_active;
   logic        i_trig_in;
   logic        i_wr_en;
   logic        i_rd_en;
   logic [7:0]  i_addr;
   logic [31:0] i_wr_data;
   logic [31:0] o_rd_data;
   logic        o_pulse_line_a;
   logic        o_pulse_line_b;
   logic [15:0] len_a;
   int          n_mismatch;
   int          comparisons;
   int          n;

   spg_top i_dut (.i_clk_sys, .i_rst_n, .i_integ_active, .i_trig_in, .i_addr,
      .i_wr_data, .i_wr_en, .i_rd_en, .o_rd_data, .o_pulse_line_a, .o_pulse_line_b);
   spg_lamp_model i_lamp_a (.i_clk_sys, .i_line(o_pulse_line_a), .o_last_len(len_a));
   spg_lamp_model i_lamp_b (.i_clk_sys, .i_line(o_pulse_line_b), .o_last_len());

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      i_wr_en <= 1'b1;
      i_addr <= a;
      i_wr_data <= d;
      @(posedge i_clk_sys);
      i_wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge i_clk_sys);
      i_rd_en <= 1'b1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_rd_en <= 1'b0;
      @(negedge i_clk_sys);
      chk(o_rd_data, e);
   endtask

   task automatic wait_a(input logic lvl);
      n = 0;
      while (o_pulse_line_a !== lvl) begin
         @(negedge i_clk_sys);
         n++;
         if (n > 2000) begin
            n_mismatch++;
            $display("mismatch at %0t: line a stuck", $time);
            complete_run();
         end
      end
   endtask

   task automatic settle();
      repeat (8) @(negedge i_clk_sys);
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end

   initial begin
      repeat (20000) @(posedge i_clk_sys);
      n_mismatch++;
      $display("mismatch at %0t: run timed out", $time);
      complete_run();
   end

   initial begin
      {i_rst_n, i_integ_active, i_trig_in, i_wr_en, i_rd_en} = 5'h0;
      i_addr = 8'h0;
      i_wr_data = 32'h0;
      n_mismatch = 0;
      comparisons = 0;
      repeat (6) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         wr(ROWS[i].addr, ROWS[i].wdat);
         rd(ROWS[i].addr, ROWS[i].rexp);
      end
      $display("test register rows done");
      @(posedge i_clk_sys) i_rst_n <= 1'b0;
      @(negedge i_clk_sys);
      chk({30'h0, o_pulse_line_b, o_pulse_line_a}, 32'h2);
      @(posedge i_clk_sys) i_rst_n <= 1'b1;
      rd(`SPG_OFS_LINE_CFG, 32'h1);
      rd(`SPG_OFS_STATUS, 32'h8);
      wr(`SPG_OFS_LINE_SEL, 32'h1);
      rd(`SPG_OFS_LINE_CFG, 32'h3);
      wr(`SPG_OFS_LINE_SEL, 32'h0);
      $display("test reset done");
      @(posedge i_clk_sys) i_integ_active <= 1'b1;
      wait_a(1'b1);
      settle();
      chk({31'h0, o_pulse_line_b}, 32'h0);
      @(posedge i_clk_sys) i_integ_active <= 1'b0;
      wait_a(1'b0);
      settle();
      chk({31'h0, o_pulse_line_b}, 32'h1);
      $display("test follow done");
      wr(`SPG_OFS_DELAY, 32'h2);
      wr(`SPG_OFS_WIDTH, 32'h3);
      @(posedge i_clk_sys) i_integ_active <= 1'b1;
      wait_a(1'b1);
      chk({31'h0, (n inside {[203:207]})}, 32'h1);
      chk({31'h0, o_pulse_line_b}, 32'h0);
      // both engines busy: line a timed, line b following integration
      rd(`SPG_OFS_STATUS, 32'h7);
      // source drops mid-pulse; a timed width must not be cut short
      repeat (50) @(posedge i_clk_sys);
      i_integ_active <= 1'b0;
      wait_a(1'b0);
      settle();
      chk({16'h0, len_a}, 32'h12c);
      wr(`SPG_OFS_DELAY, 32'h0);
      wr(`SPG_OFS_WIDTH, 32'h0);
      $display("test delay width done");
      wr(`SPG_OFS_LINE_CFG, 32'h4);
      @(posedge i_clk_sys) i_integ_active <= 1'b1;
      settle();
      chk({31'h0, o_pulse_line_a}, 32'h0);
      @(posedge i_clk_sys) i_trig_in <= 1'b1;
      settle();
      chk({31'h0, o_pulse_line_a}, 32'h1);
      wr(`SPG_OFS_LINE_CFG, 32'h6);
      settle();
      chk({31'h0, o_pulse_line_a}, 32'h0);
      wr(`SPG_OFS_LINE_CFG, 32'he);
      settle();
      chk({31'h0, o_pulse_line_a}, 32'h1);
      @(posedge i_clk_sys) i_trig_in <= 1'b0;
      settle();
      chk({31'h0, o_pulse_line_a}, 32'h0);
      wr(`SPG_OFS_LINE_CFG, 32'h6);
      @(posedge i_clk_sys) i_integ_active <= 1'b0;
      settle();
      wr(`SPG_OFS_LINE_CFG, 32'h0);
      settle();
      chk({31'h0, o_pulse_line_a}, 32'h0);
      $display("test source and polarity done");
      complete_run();
   end
endmodule
